// file: sbc_pkg.sv
package sbc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int NREQ_MS = 350;
  localparam int NREQ_CYC = NREQ_MS * CYC_PER_MS;
  localparam int WD_SHORT_MS = 10;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * CYC_PER_MS;
  localparam int WD_LONG_MS = 350;
  localparam int WD_LONG_CYC = WD_LONG_MS * CYC_PER_MS;
  localparam int RESET_CYC = 20000;
  localparam int FWU_CYC = 1_000_000;
  localparam int CS_PERIOD_CYC = 200_000;
  localparam int CS_ON_CYC = 50;
  localparam int NMI_US = 10;
  localparam int NMI_CYC = NMI_US * CYC_PER_US;
  localparam int SPI_HOLD_CYC = 50;
  localparam int CW = 22;
  localparam int HW = 8;
  localparam int SCLK_HALF = 4;
  // ----------------------------------------------------------------
  // Serial frame: [7:5] address, [4] write, [3:0] data
  // ----------------------------------------------------------------
  localparam int FRAME_W = 8;
  localparam int WR_POS = 4;
  localparam logic [2:0] A_MCR = 3'h0;
  localparam logic [2:0] A_TIM = 3'h1;
  localparam logic [2:0] A_WAKE = 3'h2;
  localparam logic [2:0] A_LPC = 3'h3;
  localparam logic [2:0] A_CAN = 3'h4;
  localparam logic [2:0] A_RCR = 3'h5;
  localparam logic [2:0] M_SLEEP = 3'h1;
  localparam logic [2:0] M_STOP = 3'h2;
  localparam logic [2:0] M_NORMAL = 3'h5;
  localparam logic [2:0] M_STANDBY = 3'h6;
  localparam logic [3:0] MCR_DEBUG = 4'h0;
  localparam int LPC_LINK = 3;
  localparam int LPC_FWU = 1;
  localparam int LPC_AUTO = 0;
  localparam int TIM_LONG = 0;
  localparam int TIM_WIN = 2;
  localparam int CAN_TXRX = 0;
  localparam int CAN_WKEN = 1;
  localparam logic [3:0] TIM_RST = 4'h4;
  localparam logic [3:0] CFG_RST = 4'h0;
  // ----------------------------------------------------------------
  // Host command registers (APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] H_CMD = 12'h000;
  localparam logic [11:0] H_STAT = 12'h004;
  localparam int ST_BUSY = 8;
  localparam int ST_RST = 9;
  localparam int ST_INT = 10;

  typedef enum {S_RESET, S_NREQ, S_NORMAL, S_STANDBY, S_SLEEP, S_STOP} mode_e;
  typedef enum {H_IDLE, H_ACT, H_TAIL, H_GAP} hst_e;
endpackage

// file: sbc_link_if.sv
`timescale 1ns/1ps
interface sbc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic rst_n;
  logic int_n;
  modport host(output sclk, output cs_n, output mosi,
               input miso, input rst_n, input int_n);
  modport dev(input sclk, input cs_n, input mosi,
              output miso, output rst_n, output int_n);
endinterface

// file: sbc_device.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module sbc_device import sbc_pkg::*; #(
  parameter int NREQ_CYCLES = NREQ_CYC,
  parameter int RESET_CYCLES = RESET_CYC,
  parameter int WD_SHORT_CYCLES = WD_SHORT_CYC,
  parameter int WD_LONG_CYCLES = WD_LONG_CYC,
  parameter int FWU_CYCLES = FWU_CYC,
  parameter int CS_PERIOD_CYCLES = CS_PERIOD_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  sbc_link_if.dev LINK,
  input wire logic [3:0] WAKE_IN,
  input wire logic TXD,
  input wire logic BUS_DOM,
  input wire logic CAN_WAKE,
  output logic RXD,
  output logic CAN_DRIVE_DOM,
  output logic HS_ON,
  output logic VDD_EN,
  output logic WATCHDOG_FAULT_OUTPUT_N
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] in_s1, in_s2;
  logic sclk_d, cs_d;
  always_ff @(posedge CLK) begin
    in_s1 <= {CAN_WAKE, BUS_DOM, TXD, WAKE_IN, LINK.mosi, LINK.cs_n,
              LINK.sclk};
    in_s2 <= in_s1;
    sclk_d <= in_s2[0];
    cs_d <= in_s2[1];
  end
  logic [3:0] wk_s;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign wk_s = in_s2[6:3];
  assign sclk_rise = in_s2[0] & ~sclk_d;
  assign sclk_fall = ~in_s2[0] & sclk_d;
  assign cs_fall = ~in_s2[1] & cs_d;
  assign cs_rise = in_s2[1] & ~cs_d;

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  logic [7:0] rx_q, tx_q, resp_q;
  logic [3:0] bits_q;
  logic [HW-1:0] hold_q;
  logic frame_v, spi_ok, wr, rd;
  logic [2:0] addr;
  logic [3:0] dat;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      bits_q <= 4'h0;
    end else if (cs_fall) begin
      tx_q <= resp_q;
      bits_q <= 4'h0;
    end else if (!in_s2[1]) begin
      if (sclk_rise) begin
        rx_q <= {rx_q[6:0], in_s2[2]};
        bits_q <= bits_q + 4'h1;
      end
      if (sclk_fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end
  assign LINK.miso = tx_q[7];
  assign spi_ok = hold_q == '0;
  assign frame_v = cs_rise && bits_q == 4'(FRAME_W) && spi_ok;
  assign addr = rx_q[7:5];
  assign dat = rx_q[3:0];
  assign wr = frame_v && rx_q[WR_POS];
  assign rd = frame_v && !rx_q[WR_POS];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  mode_e mode_q, mode_d;
  logic [3:0] tim_q, wcfg_q, lpc_q, can_q, rcr_q;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tim_q <= TIM_RST;
      wcfg_q <= CFG_RST;
      lpc_q <= CFG_RST;
      can_q <= CFG_RST;
      rcr_q <= CFG_RST;
    end else if (wr) begin
      case (addr)
        A_TIM: tim_q <= dat;
        A_WAKE: wcfg_q <= dat;
        A_LPC: begin
          lpc_q <= dat;
          if (dat[LPC_LINK] && dat[LPC_AUTO]) begin
            lpc_q[LPC_FWU] <= 1'b0;
          end
        end
        A_CAN: can_q <= dat;
        A_RCR: rcr_q <= dat;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------
  function automatic logic lvl_hit(input logic [1:0] cfg,
                                   input logic now, input logic snap);
    case (cfg)
      2'b01: lvl_hit = now;
      2'b10: lvl_hit = !now;
      2'b11: lvl_hit = now != snap;
      default: lvl_hit = 1'b0;
    endcase
  endfunction

  logic [3:0] snap_q, hit, src_q;
  logic [CW-1:0] lp_q, lp_per;
  logic lowp, direct, cyclic, fwu_en, samp, in_wake, can_wk, wake;
  logic bus_wake_q;
  assign lowp = mode_q == S_SLEEP || mode_q == S_STOP;
  assign direct = !lpc_q[LPC_LINK] && !lpc_q[LPC_AUTO];
  assign cyclic = lpc_q[LPC_LINK] && lpc_q[LPC_AUTO];
  assign fwu_en = lpc_q[LPC_FWU] && !cyclic;
  assign lp_per = cyclic ? CW'(CS_PERIOD_CYCLES) : CW'(FWU_CYCLES);
  assign samp = lp_q == lp_per - CW'(1);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit[i] = lvl_hit(i < 2 ? wcfg_q[1:0] : wcfg_q[3:2],
                       wk_s[i], snap_q[i]);
    end
  end
  // One sampling mode for all inputs; level mode per pair (wcfg_q[1:0] for inputs 0-1, wcfg_q[3:2] for 2-3).
  assign in_wake = (direct || (cyclic && samp)) && |hit;
  assign can_wk = can_q[CAN_WKEN] && in_s2[9];
  assign wake = lowp && (in_wake || can_wk || cs_rise
                || (fwu_en && samp));

  always_ff @(posedge CLK) begin
    if (!RESETN || !lowp || !(cyclic || fwu_en) || samp) begin
      lp_q <= '0;
    end else begin
      lp_q <= lp_q + CW'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (!lowp) begin
      snap_q <= wk_s;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      HS_ON <= 1'b0;
    end else begin
      HS_ON <= lowp && cyclic
               && lp_q >= lp_per - CW'(CS_ON_CYC);
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      src_q <= 4'h0;
      bus_wake_q <= 1'b0;
    end else begin
      src_q <= ((rd && addr == A_WAKE) ? 4'h0 : src_q)
               | ((wake && in_wake) ? hit : 4'h0);
      bus_wake_q <= ((rd && addr == A_CAN) ? 1'b0 : bus_wake_q)
                    | (wake && can_wk);
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer and watchdog
  // ----------------------------------------------------------------
  logic [CW-1:0] tmr_q, seq_tmr_q, per;
  logic [1:0] seq_q;
  logic debug_q, batfail_q, wd_run, expire, closed, tim_wr, mcr_wr;
  logic wd_to, seq_to, mode_code;
  assign tim_wr = wr && addr == A_TIM;
  assign mcr_wr = wr && addr == A_MCR;
  assign mode_code = dat[2:0] == M_NORMAL || dat[2:0] == M_STANDBY;
  assign wd_run = !debug_q && (mode_q == S_NORMAL || mode_q == S_STANDBY
                  || (mode_q == S_STOP && rcr_q[0]));
  always_comb begin
    case (mode_q)
      S_RESET: per = CW'(RESET_CYCLES);
      S_NREQ: per = CW'(NREQ_CYCLES);
      default: per = tim_q[TIM_LONG] ? CW'(WD_LONG_CYCLES)
                                     : CW'(WD_SHORT_CYCLES);
    endcase
  end
  assign expire = tmr_q == per - CW'(1);
  assign closed = tim_q[TIM_WIN] && mode_q != S_STOP
                  && tmr_q < (per >> 1);
  assign wd_to = wd_run && (expire || (tim_wr && closed));
  assign seq_to = seq_q != 2'd0 && seq_tmr_q >= CW'(NREQ_CYCLES - 1);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      S_RESET: if (expire) mode_d = S_NREQ;
      S_NREQ: begin
        if (expire) begin
          mode_d = S_RESET;
        end else if (tim_wr && !debug_q) begin
          mode_d = S_NORMAL;
        end else if (mcr_wr && debug_q && mode_code) begin
          mode_d = dat[2:0] == M_NORMAL ? S_NORMAL : S_STANDBY;
        end
      end
      S_NORMAL, S_STANDBY: begin
        if (wd_to || seq_to) begin
          mode_d = S_RESET;
        end else if (mcr_wr) begin
          case (dat[2:0])
            M_SLEEP: mode_d = S_SLEEP;
            M_STOP: mode_d = S_STOP;
            M_NORMAL: mode_d = S_NORMAL;
            M_STANDBY: mode_d = S_STANDBY;
            default: ;
          endcase
        end
      end
      S_SLEEP: if (wake) mode_d = S_RESET;
      S_STOP: begin
        if (wd_to) begin
          mode_d = S_RESET;
        end else if (wake) begin
          mode_d = S_NREQ;
        end
      end
      default: mode_d = S_RESET;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      mode_q <= S_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN || mode_d != mode_q || (tim_wr && !wd_to)) begin
      tmr_q <= '0;
    end else if (!expire) begin
      tmr_q <= tmr_q + CW'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN || mode_q == S_RESET || seq_q == 2'd0) begin
      seq_tmr_q <= '0;
    end else begin
      seq_tmr_q <= seq_tmr_q + CW'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      seq_q <= 2'd0;
      debug_q <= 1'b0;
      batfail_q <= 1'b1;
    end else if (mode_d == S_RESET && !lowp) begin
      seq_q <= 2'd0;
      debug_q <= 1'b0;
    end else if (wr) begin
      seq_q <= 2'd0;
      if (tim_wr && mode_q == S_NREQ && batfail_q && !debug_q) begin
        seq_q <= 2'd1;
      end else if (mcr_wr && dat == MCR_DEBUG && seq_q == 2'd1) begin
        seq_q <= 2'd2;
      end else if (mcr_wr && seq_q == 2'd2 && mode_code) begin
        debug_q <= 1'b1;
        batfail_q <= 1'b0;
      end else if (mcr_wr && dat == MCR_DEBUG) begin
        debug_q <= 1'b0;
        batfail_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins and read-back
  // ----------------------------------------------------------------
  logic rst_n_q, int_n_q;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rst_n_q <= 1'b0;
      VDD_EN <= 1'b1;
      WATCHDOG_FAULT_OUTPUT_N <= 1'b1;
      int_n_q <= 1'b1;
      hold_q <= '0;
    end else begin
      rst_n_q <= mode_d != S_RESET;
      VDD_EN <= mode_d != S_SLEEP;
      if (wd_to) begin
        WATCHDOG_FAULT_OUTPUT_N <= 1'b0;
      end else if (tim_wr) begin
        WATCHDOG_FAULT_OUTPUT_N <= 1'b1;
      end
      if (mode_q == S_STOP && mode_d == S_NREQ) begin
        hold_q <= HW'(NMI_CYC + SPI_HOLD_CYC);
        int_n_q <= 1'b0;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - HW'(1);
        if (hold_q == HW'(SPI_HOLD_CYC + 1)) begin
          int_n_q <= 1'b1;
        end
      end
    end
  end
  assign LINK.rst_n = rst_n_q;
  assign LINK.int_n = int_n_q;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      resp_q <= 8'h00;
    end else if (rd) begin
      resp_q[7:4] <= {addr, 1'b0};
      case (addr)
        A_MCR: resp_q[3:0] <= {batfail_q, debug_q, !WATCHDOG_FAULT_OUTPUT_N, 1'b0};
        A_TIM: resp_q[3:0] <= tim_q;
        A_WAKE: resp_q[3:0] <= src_q;
        A_LPC: resp_q[3:0] <= lpc_q;
        A_CAN: resp_q[3:0] <= {bus_wake_q, 1'b0, can_q[1:0]};
        A_RCR: resp_q[3:0] <= rcr_q;
        default: resp_q[3:0] <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CAN_DRIVE_DOM <= 1'b0;
      RXD <= 1'b1;
    end else begin
      CAN_DRIVE_DOM <= can_q[CAN_TXRX] && !in_s2[7];
      RXD <= can_q[CAN_TXRX] ? !in_s2[8] : 1'b1;
    end
  end
endmodule // sbc_device

// file: sbc_host.sv
`timescale 1ns/1ps
module sbc_host import sbc_pkg::*; #(
  parameter int HALF = SCLK_HALF
) (
  input wire logic CLK,
  input wire logic RESETN,
  sbc_link_if.host LINK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // ----------------------------------------------------------------
  // Device line synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1, s2;
  always_ff @(posedge CLK) begin
    s1 <= {LINK.int_n, LINK.rst_n, LINK.miso};
    s2 <= s1;
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  hst_e st_q;
  logic [7:0] rx_q, tx_q;
  logic start;
  assign start = PSEL && !PENABLE && PWRITE && PADDR == H_CMD
                 && st_q == H_IDLE;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && PADDR != H_CMD && PADDR != H_STAT;
      PRDATA <= 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE && PADDR == H_STAT) begin
        PRDATA[7:0] <= rx_q;
        PRDATA[ST_BUSY] <= st_q != H_IDLE || start;
        PRDATA[ST_RST] <= s2[1];
        PRDATA[ST_INT] <= s2[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial master: one frame per command write
  // ----------------------------------------------------------------
  logic [HW-1:0] div_q;
  logic [4:0] hc_q;
  logic tick, sclk_q, cs_n_q;
  assign tick = div_q == HW'(HALF - 1);
  always_ff @(posedge CLK) begin
    if (!RESETN || st_q == H_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + HW'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q <= H_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      hc_q <= 5'd0;
    end else begin
      case (st_q)
        H_IDLE: if (start) begin
          tx_q <= PWDATA[7:0];
          cs_n_q <= 1'b0;
          hc_q <= 5'd0;
          st_q <= H_ACT;
        end
        H_ACT: if (tick) begin
          hc_q <= hc_q + 5'd1;
          sclk_q <= !hc_q[0];
          if (hc_q[0]) begin
            rx_q <= {rx_q[6:0], s2[0]};
            tx_q <= {tx_q[6:0], 1'b0};
          end
          if (hc_q == 5'd15) begin
            st_q <= H_TAIL;
          end
        end
        H_TAIL: if (tick) begin
          cs_n_q <= 1'b1;
          st_q <= H_GAP;
        end
        // A short gap keeps cs_n high for at least one tick between frames.
        H_GAP: if (tick) st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end
  assign LINK.sclk = sclk_q;
  assign LINK.cs_n = cs_n_q;
  assign LINK.mosi = tx_q[7];
endmodule // sbc_host

// file: sbc_monitor.sv
`timescale 1ns/1ps
module sbc_monitor import sbc_pkg::*; #(
  parameter int RST_CYC = 200
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic rst_n,
  input wire logic int_n
);
  int lo_q;
  int int_lo_q;
  int bits_q;
  logic sclk_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // ------------------------------------------------------------
  // Counters of low time and of serial bits
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN || rst_n) lo_q <= 0;
    else lo_q <= lo_q + 1;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN || int_n) int_lo_q <= 0;
    else int_lo_q <= int_lo_q + 1;
  end

  always_ff @(posedge CLK) sclk_q <= sclk;

  always_ff @(posedge CLK) begin
    if (!RESETN || cs_n) bits_q <= 0;
    else if (sclk && !sclk_q) bits_q <= bits_q + 1;
  end

  sequence s_high_half;
    sclk [*4] ##1 !sclk;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock active outside a frame");
  a_sclk_half: assert property ($rose(sclk) |-> s_high_half)
    else $error("serial clock high phase has wrong length");
  a_mosi_hold: assert property ($rose(sclk) |=> $stable(mosi) [*3])
    else $error("data line moved while serial clock high");
  a_frame_bits: assert property ($rose(cs_n) |-> bits_q == 8)
    else $error("frame closed without eight bits");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("frames closer than four cycles");
  a_rst_len: assert property ($rose(rst_n) |-> lo_q >= RST_CYC - 2)
    else $error("reset released too early");
  a_int_width: assert property ($rose(int_n) |-> int_lo_q == NMI_CYC)
    else $error("interrupt pulse has wrong width");
  a_int_awake: assert property (!int_n |-> rst_n)
    else $error("interrupt pulse during reset");
  a_miso_idle: assert property (cs_n |-> !miso)
    else $error("reply line high outside a frame");
endmodule // sbc_monitor

// file: tb.sv
`timescale 1ns/1ps
module tb import sbc_pkg::*;;
  localparam int NREQ = 2000;
  localparam int RSTC = 200;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, TXD, BUS_DOM, CAN_WAKE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, stat;
  logic PREADY, PSLVERR, RXD, CAN_DRIVE_DOM, HS_ON, VDD_EN, WATCHDOG_FAULT_OUTPUT_N;
  logic slverr;
  logic [3:0] WAKE_IN;
  logic [6:0] obs;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int lows = 0;

  sbc_link_if lnk();
  assign obs = {HS_ON, CAN_DRIVE_DOM, RXD, WATCHDOG_FAULT_OUTPUT_N, VDD_EN, lnk.int_n, lnk.rst_n};

  sbc_host u_sbc_host (.CLK(CLK), .RESETN(RESETN), .LINK(lnk.host),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  sbc_device #(.NREQ_CYCLES(NREQ), .RESET_CYCLES(RSTC),
    .WD_SHORT_CYCLES(500), .WD_LONG_CYCLES(2000), .FWU_CYCLES(300),
    .CS_PERIOD_CYCLES(300)) u_sbc_device (.CLK(CLK), .RESETN(RESETN),
    .LINK(lnk.dev), .WAKE_IN(WAKE_IN), .TXD(TXD), .BUS_DOM(BUS_DOM),
    .CAN_WAKE(CAN_WAKE), .RXD(RXD), .CAN_DRIVE_DOM(CAN_DRIVE_DOM),
    .HS_ON(HS_ON), .VDD_EN(VDD_EN), .WATCHDOG_FAULT_OUTPUT_N(WATCHDOG_FAULT_OUTPUT_N));
  sbc_monitor #(.RST_CYC(RSTC)) u_sbc_monitor (.CLK(CLK), .RESETN(RESETN),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
    .rst_n(lnk.rst_n), .int_n(lnk.int_n));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (lnk.rst_n === 1'b0)
      lows <= lows + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK);
    while (PREADY !== 1'b1);
    r = PRDATA;
    slverr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic spi(input logic [7:0] b);
    apb(1'b1, H_CMD, {24'h0, b}, stat);
    do apb(1'b0, H_STAT, 32'h0, stat);
    while (stat[ST_BUSY] !== 1'b0);
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [3:0] d);
    spi({a, 5'h00});
    spi({A_RCR, 5'h00});
    chk({29'h0, stat[7:5]}, {29'h0, a});
    d = stat[3:0];
  endtask

  task automatic wait_obs(input int i, input logic v, input int mx,
                          output int n);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (obs[i] !== v && n < mx);
    chk({31'h0, obs[i]}, {31'h0, v});
    @(posedge CLK);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    logic [3:0] d;
    RESETN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    TXD = 1'b1;
    BUS_DOM = 1'b0;
    CAN_WAKE = 1'b0;
    WAKE_IN = 4'h0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({25'h0, obs}, 32'h1E);
    @(posedge CLK);
    RESETN <= 1'b1;
    wait_obs(0, 1'b1, RSTC + 20, n);
    wait_obs(0, 1'b0, NREQ + 20, n);
    chk({31'h0, n > NREQ - 20}, 32'h1);
    wait_obs(0, 1'b1, RSTC + 20, n);
    spi(8'h31);
    wait_obs(0, 1'b0, NREQ + 20, n);
    wait_obs(0, 1'b1, RSTC + 20, n);
    spi(8'h31);
    spi(8'h10);
    spi(8'h15);
    rd_reg(A_MCR, d);
    chk({31'h0, d[2]}, 32'h1);
    n = lows;
    repeat (3000) @(posedge CLK);
    chk(32'(lows - n), 32'h0);
    wait_obs(3, 1'b1, 1, n);
    spi(8'h31);
    spi(8'h10);
    rd_reg(A_MCR, d);
    chk({31'h0, d[2]}, 32'h0);
    spi(8'h35);
    spi(8'h35);
    wait_obs(3, 1'b0, 50, n);
    wait_obs(0, 1'b0, 1, n);
    wait_obs(0, 1'b1, RSTC + 20, n);
    wait_obs(3, 1'b0, 1, n);
    spi(8'h31);
    wait_obs(3, 1'b1, 1, n);
    apb(1'b0, 12'h008, 32'h0, stat);
    chk({31'h0, slverr}, 32'h1);
    spi(8'h91);
    spi(8'h16);
    for (int i = 0; i < 4; i++) begin
      TXD <= i[0];
      BUS_DOM <= i[1];
      repeat (5) @(negedge CLK);
      chk({30'h0, obs[5:4]}, {30'h0, ~i[0], ~i[1]});
      @(posedge CLK);
    end
    TXD <= 1'b1;
    BUS_DOM <= 1'b0;
    spi(8'h31);
    spi(8'h51);
    spi(8'h70);
    WAKE_IN <= 4'h2;
    repeat (20) @(posedge CLK);
    WAKE_IN <= 4'h0;
    rd_reg(A_WAKE, d);
    chk({28'h0, d}, 32'h0);
    spi(8'h11);
    wait_obs(2, 1'b0, 20, n);
    WAKE_IN <= 4'h4;
    repeat (50) @(posedge CLK);
    wait_obs(2, 1'b0, 1, n);
    WAKE_IN <= 4'h6;
    wait_obs(2, 1'b1, 50, n);
    wait_obs(0, 1'b0, 1, n);
    WAKE_IN <= 4'h0;
    wait_obs(0, 1'b1, RSTC + 20, n);
    spi(8'h31);
    rd_reg(A_WAKE, d);
    chk({28'h0, d}, 32'h2);
    spi(8'h92);
    spi(8'h12);
    CAN_WAKE <= 1'b1;
    wait_obs(1, 1'b0, 600, n);
    wait_obs(2, 1'b1, 1, n);
    CAN_WAKE <= 1'b0;
    repeat (200) @(posedge CLK);
    spi(8'h31);
    rd_reg(A_CAN, d);
    chk({31'h0, d[3]}, 32'h1);
    spi(8'h7B);
    rd_reg(A_LPC, d);
    chk({28'h0, d}, 32'h9);
    spi(8'h12);
    wait_obs(6, 1'b1, 400, n);
    spi(8'h50);
    wait_obs(1, 1'b0, 50, n);
    apb(1'b0, H_STAT, 32'h0, stat);
    chk({30'h0, stat[ST_INT], stat[ST_RST]}, 32'h1);
    repeat (200) @(posedge CLK);
    spi(8'h31);
    spi(8'hB1);
    spi(8'h12);
    wait_obs(0, 1'b0, 2100, n);
    wait_obs(3, 1'b0, 1, n);
    tally_and_finish();
  end
endmodule // tb
